// ==== rtl/fth_top.sv ====
// FIFO flag logic with programmable almost-empty and almost-full thresholds.
// Assumes one 10 MHz clock, APB from software and fabric strobes synchronous to it.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

// Contract
// - Almost-empty rises when read level reaches threshold.
// - Almost-empty holds until level exceeds threshold.
// - Almost-full in write entries, almost-empty in read.
// - Thresholds are twelve bits, parity bits ignored.
// - Empty while no whole read word stored.
// - Full while no whole write word fits.
module fth_top (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    output logic             empty_o,
    output logic             full_o,
    output logic             almost_empty_flag_o,
    output logic             almost_full_flag_o,
    output logic             irq_o
);
    import fth_pkg::*;

    fth_width_t               wr_code_q;
    fth_width_t               rd_code_q;
    fth_thr_t                 almost_empty_threshold_q;
    fth_thr_t                 almost_full_threshold_q;
    logic [`FTH_INT_W-1:0]    int_stat_q;
    logic [`FTH_INT_W-1:0]    int_mask_q;
    logic [`FTH_INT_W-1:0]    int_evt;
    logic [31:0]              rdata;
    logic                     rd_hit;
    logic                     apb_acc;
    logic                     apb_do;
    logic                     flush;
    logic                     wr_acc;
    logic                     rd_acc;
    logic                     ae_d;
    logic                     af_d;
    fth_fill_t                fill_d;
    fth_fill_t                fill_q;

    assign apb_acc = psel_i && penable_i && !pready_o;
    assign apb_do  = psel_i && penable_i && pready_o;
    assign flush   = apb_do && pwrite_i && (paddr_i == `FTH_OFS_CTRL)
                     && pwdata_i[`FTH_CTRL_FLUSH];

    // A refused strobe is dropped, which keeps half words out of the store.
    assign wr_acc = wr_en_i && !full_o;
    assign rd_acc = rd_en_i && !empty_o;

    fth_level u_level (
        .clock_i   (clock_i),
        .rstn_i    (rstn_i),
        .flush_i   (flush),
        .wr_acc_i  (wr_acc),
        .rd_acc_i  (rd_acc),
        .wr_code_i (wr_code_q),
        .rd_code_i (rd_code_q),
        .fill_d_o  (fill_d),
        .fill_q_o  (fill_q)
    );

    // Levels are rounded to each port's own entry size before comparison.
    assign ae_d = fth_round(fill_d, rd_code_q)
                  <= {1'b0, almost_empty_threshold_q};
    assign af_d = fth_round(fill_d, wr_code_q)
                  >= {1'b0, almost_full_threshold_q};

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            empty_o             <= 1'b1;
            full_o              <= 1'b0;
            almost_empty_flag_o <= 1'b1;
            almost_full_flag_o  <= 1'b0;
        end else begin
            empty_o             <= fill_d < fth_bits(rd_code_q);
            full_o              <= (`FTH_CAP_BITS - fill_d) < fth_bits(wr_code_q);
            almost_empty_flag_o <= ae_d;
            almost_full_flag_o  <= af_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            wr_code_q                <= fth_width_t'(`FTH_CTRL_RST);
            rd_code_q                <= fth_width_t'(`FTH_CTRL_RST);
            almost_empty_threshold_q <= `FTH_ALMOST_EMPTY_THRESHOLD_RST;
            almost_full_threshold_q  <= `FTH_ALMOST_FULL_THRESHOLD_RST;
            int_mask_q               <= `FTH_MASK_RST;
        end else if (apb_do && pwrite_i) begin
            case (paddr_i)
                `FTH_OFS_CTRL: begin
                    wr_code_q <= fth_width_t'(pwdata_i[`FTH_CTRL_WR_LSB +: 3]);
                    rd_code_q <= fth_width_t'(pwdata_i[`FTH_CTRL_RD_LSB +: 3]);
                end
                `FTH_OFS_ALMOST_EMPTY_THRESHOLD: begin
                    almost_empty_threshold_q <= pwdata_i[`FTH_THR_W-1:0];
                end
                `FTH_OFS_ALMOST_FULL_THRESHOLD: begin
                    almost_full_threshold_q <= pwdata_i[`FTH_THR_W-1:0];
                end
                `FTH_OFS_INT_MASK: begin
                    int_mask_q <= pwdata_i[`FTH_INT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        int_evt                 = '0;
        int_evt[`FTH_INT_AE]    = ae_d && !almost_empty_flag_o;
        int_evt[`FTH_INT_AF]    = af_d && !almost_full_flag_o;
        int_evt[`FTH_INT_OVF]   = wr_en_i && full_o;
        int_evt[`FTH_INT_UNF]   = rd_en_i && empty_o;
    end

    // A new event in the clearing cycle survives the write-one-to-clear.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            int_stat_q <= '0;
        end else if (apb_do && pwrite_i && (paddr_i == `FTH_OFS_INT_STAT)) begin
            int_stat_q <= (int_stat_q & ~pwdata_i[`FTH_INT_W-1:0]) | int_evt;
        end else begin
            int_stat_q <= int_stat_q | int_evt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_stat_q & int_mask_q);
        end
    end

    always_comb begin
        rdata  = '0;
        rd_hit = 1'b1;
        case (paddr_i)
            `FTH_OFS_CTRL: begin
                rdata[`FTH_CTRL_WR_LSB +: 3] = wr_code_q;
                rdata[`FTH_CTRL_RD_LSB +: 3] = rd_code_q;
            end
            `FTH_OFS_ALMOST_EMPTY_THRESHOLD:    rdata[`FTH_THR_W-1:0] = almost_empty_threshold_q;
            `FTH_OFS_ALMOST_FULL_THRESHOLD:    rdata[`FTH_THR_W-1:0] = almost_full_threshold_q;
            `FTH_OFS_STATUS: begin
                rdata[`FTH_FILL_W-1:0]          = fill_q;
                rdata[`FTH_STAT_FLG_LSB +: 4]   = {almost_full_flag_o, almost_empty_flag_o,
                                                   full_o, empty_o};
            end
            `FTH_OFS_INT_STAT: rdata[`FTH_INT_W-1:0] = int_stat_q;
            `FTH_OFS_INT_MASK: rdata[`FTH_INT_W-1:0] = int_mask_q;
            default:           rd_hit = 1'b0;
        endcase
    end

    // One wait state lets read data come from a flop in step with pready.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= apb_acc;
            pslverr_o <= apb_acc && !rd_hit;
            if (apb_acc && !pwrite_i) begin
                prdata_o <= rdata;
            end
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    AST_EMPTY_WORD: assert property (
        empty_o == (fill_q < fth_bits($past(rd_code_q))))
        else $error("empty flag disagrees with whole read word");

    AST_FULL_WORD: assert property (
        full_o == ((`FTH_CAP_BITS - fill_q) < fth_bits($past(wr_code_q))))
        else $error("full flag disagrees with whole write word");

    AST_AE_SET: assert property (
        rd_acc && !wr_acc && !flush
        && fth_round(fill_d, rd_code_q) <= {1'b0, almost_empty_threshold_q}
        |=> almost_empty_flag_o)
        else $error("almost-empty not raised on read to threshold");

    AST_AE_HOLD: assert property (
        almost_empty_flag_o && !rd_acc && !wr_acc && !flush && !(apb_do && pwrite_i)
        && !$past(apb_do && pwrite_i)
        |=> almost_empty_flag_o)
        else $error("almost-empty dropped without level change");

    AST_AE_LEVEL: assert property (
        !almost_empty_flag_o |->
        fth_round(fill_q, $past(rd_code_q)) > {1'b0, $past(almost_empty_threshold_q)})
        else $error("almost-empty low at or below threshold");

    AST_AF_LEVEL: assert property (
        almost_full_flag_o ==
        (fth_round(fill_q, $past(wr_code_q)) >= {1'b0, $past(almost_full_threshold_q)}))
        else $error("almost-full disagrees with write level");

    AST_THR_WIDTH: assert property (
        apb_do && !pwrite_i && (paddr_i == `FTH_OFS_ALMOST_EMPTY_THRESHOLD || paddr_i == `FTH_OFS_ALMOST_FULL_THRESHOLD)
        |-> prdata_o[31:`FTH_THR_W] == '0
        && prdata_o[`FTH_THR_W-1:0] == ((paddr_i == `FTH_OFS_ALMOST_EMPTY_THRESHOLD) ? almost_empty_threshold_q
                                                                   : almost_full_threshold_q))
        else $error("threshold read back wrong or wider than twelve bits");

    AST_NO_OVERFILL: assert property (
        wr_en_i && full_o |=> fill_q <= $past(fill_q))
        else $error("write accepted while full");

    AST_IRQ: assert property (
        |(int_stat_q & int_mask_q) |=> irq_o)
        else $error("interrupt not raised for unmasked status");

    COV_FULL:  cover property (wr_acc ##1 full_o);
    COV_AE_UP: cover property (!almost_empty_flag_o ##1 almost_empty_flag_o);
    COV_MIXED: cover property (wr_code_q != rd_code_q && wr_acc ##1 empty_o);

endmodule // fth_top

// ==== inc/fth_defines.svh ====
// Constants of the FIFO threshold flag block: register offsets, fields, resets.
// Assumes a 32-bit APB register bus and a 4096 data-bit FIFO store.
`ifndef FTH_DEFINES_SVH
`define FTH_DEFINES_SVH

`define FTH_CAP_BITS      13'h1000
`define FTH_FILL_W        13
`define FTH_THR_W         12

`define FTH_OFS_CTRL      12'h000
`define FTH_OFS_ALMOST_EMPTY_THRESHOLD     12'h004
`define FTH_OFS_ALMOST_FULL_THRESHOLD     12'h008
`define FTH_OFS_STATUS    12'h00c
`define FTH_OFS_INT_STAT  12'h010
`define FTH_OFS_INT_MASK  12'h014

`define FTH_CTRL_WR_LSB   0
`define FTH_CTRL_RD_LSB   4
`define FTH_CTRL_FLUSH    8
`define FTH_STAT_FLG_LSB  16

`define FTH_INT_AE        0
`define FTH_INT_AF        1
`define FTH_INT_OVF       2
`define FTH_INT_UNF       3
`define FTH_INT_W         4

`define FTH_CTRL_RST      3'h0
`define FTH_ALMOST_EMPTY_THRESHOLD_RST     12'h000
`define FTH_ALMOST_FULL_THRESHOLD_RST     12'hfff
`define FTH_MASK_RST      4'h0

`endif

// ==== inc/fth_pkg.sv ====
// Types and width helpers of the FIFO threshold flag block.
// Assumes the constants header is on the include path.
`include "fth_defines.svh"

package fth_pkg;

    typedef enum logic [2:0] {
        FTH_W1,
        FTH_W2,
        FTH_W4,
        FTH_W9,
        FTH_W18
    } fth_width_t;

    typedef logic [`FTH_FILL_W-1:0] fth_fill_t;
    typedef logic [`FTH_THR_W-1:0]  fth_thr_t;

    // Parity bits are not counted, so nine and eighteen bits count as eight and sixteen.
    function automatic fth_fill_t fth_bits(input fth_width_t code);
        fth_fill_t one;
        one = `FTH_FILL_W'(1);
        case (code)
            FTH_W2:  fth_bits = one << 1;
            FTH_W4:  fth_bits = one << 2;
            FTH_W9:  fth_bits = one << 3;
            FTH_W18: fth_bits = one << 4;
            default: fth_bits = one;
        endcase
    endfunction

    // Level rounded down to whole entries of the given port width.
    function automatic fth_fill_t fth_round(input fth_fill_t fill, input fth_width_t code);
        fth_round = fill & ~(fth_bits(code) - `FTH_FILL_W'(1));
    endfunction

endpackage

// ==== rtl/fth_level.sv ====
// Fill level of the FIFO store, counted in data bits.
// Assumes the caller only accepts a write while space is free and a read while data is there.
`timescale 1ns/10ps

module fth_level (
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    input  wire logic              flush_i,
    input  wire logic              wr_acc_i,
    input  wire logic              rd_acc_i,
    input  fth_pkg::fth_width_t    wr_code_i,
    input  fth_pkg::fth_width_t    rd_code_i,
    output fth_pkg::fth_fill_t     fill_d_o,
    output fth_pkg::fth_fill_t     fill_q_o
);
    import fth_pkg::*;

    fth_fill_t fill_q;
    fth_fill_t fill_d;

    always_comb begin
        fill_d = fill_q;
        if (wr_acc_i) begin
            fill_d = fill_d + fth_bits(wr_code_i);
        end
        if (rd_acc_i) begin
            fill_d = fill_d - fth_bits(rd_code_i);
        end
        if (flush_i) begin
            fill_d = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            fill_q <= '0;
        end else begin
            fill_q <= fill_d;
        end
    end

    assign fill_d_o = fill_d;
    assign fill_q_o = fill_q;

endmodule // fth_level

// ==== bench/fth_fabric.sv ====
// Fabric-side model that writes and reads the FIFO with single-edge strobes.
// Assumes the caller paces requests; strobes change just after a rising edge.
`timescale 1ns/10ps

module fth_fabric (
    input  wire logic clock_i,
    output logic      wr_en_o,
    output logic      rd_en_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
    end

    // Strobes stand for exactly one taking edge, so no access is taken twice.
    task automatic xfer(input logic w, input logic r);
        @(posedge clock_i);
        wr_en_o <= w;
        rd_en_o <= r;
        @(posedge clock_i);
        wr_en_o <= 1'b0;
        rd_en_o <= 1'b0;
    endtask
endmodule // fth_fabric

// ==== bench/fth_top_test.sv ====
// Self-checking bench of the FIFO flag block: APB master, fabric model, fill model.
// Assumes the block answers APB with pready and updates flags on the taking edge.
`timescale 1ns/10ps

module fth_top_test;
    logic        clock_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rdata;
    logic        pready_o, pslverr_o, wr_en_i, rd_en_i, empty_o, full_o, irq_o, rerr;
    logic        almost_empty_flag_o, almost_full_flag_o;
    int          n_fail = 0;
    int          comparisons = 0;
    int          fill = 0, wb = 1, rb = 1, almost_empty_threshold = 0, almost_full_threshold = 4095;

    always #50 clock_i = ~clock_i;

    fth_top uut (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .wr_en_i, .rd_en_i, .empty_o, .full_o,
        .almost_empty_flag_o, .almost_full_flag_o, .irq_o);
    fth_fabric fab (.clock_i(clock_i), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i));

    task automatic complete_run();
        if (n_fail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rdata = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            $display("[FAIL] %0t no bus answer", $time);
            n_fail++;
            complete_run();
        end
    endtask

    function automatic int bits(input int c);
        return (c == 1) ? 2 : (c == 2) ? 4 : (c == 3) ? 8 : (c == 4) ? 16 : 1;
    endfunction

    // Flush with the width change so the bench model restarts from an empty store.
    task automatic cfg(input int wc, input int rc, input int ae, input int af);
        apb(1'b1, 12'h000, 32'(32'h100 | (rc << 4) | wc));
        apb(1'b1, 12'h004, 32'(ae));
        apb(1'b1, 12'h008, 32'(af));
        fill = 0;
        wb = bits(wc);
        rb = bits(rc);
        almost_empty_threshold = ae;
        almost_full_threshold = af;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic step(input logic w, input logic r);
        logic wok, rok;
        wok = w && (4096 - fill >= wb);
        rok = r && (fill >= rb);
        fab.xfer(w, r);
        fill = fill + (wok ? wb : 0) - (rok ? rb : 0);
        #1;
        chkb(empty_o, fill < rb);
        chkb(full_o, 4096 - fill < wb);
        chkb(almost_empty_flag_o, (fill / rb * rb) <= almost_empty_threshold);
        chkb(almost_full_flag_o, (fill / wb * wb) >= almost_full_threshold);
    endtask

    initial begin
        void'($urandom(32'he4bc272e));
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        #1;
        chkb(empty_o, 1'b1);
        chkb(almost_empty_flag_o, 1'b1);
        chkb(irq_o, 1'b0);
        apb(1'b0, 12'hffc, 32'h0);
        chkb(rerr, 1'b1);
        cfg(1, 2, 0, 4095);
        repeat (2) step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        cfg(3, 4, 2 * 16, 5 * 8);
        repeat (6) step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        repeat (2) step(1'b1, 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        chk({19'h0, rdata[12:0]}, 32'(fill));
        cfg(2, 1, 0, 4092);
        repeat (1025) step(1'b1, 1'b0);
        chkb(irq_o, 1'b0);
        apb(1'b1, 12'h014, 32'h4);
        repeat (2) @(posedge clock_i);
        chkb(irq_o, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk(rdata & 32'h4, 32'h4);
        apb(1'b1, 12'h010, 32'hf);
        repeat (2) @(posedge clock_i);
        chkb(irq_o, 1'b0);
        repeat (2) step(1'b0, 1'b1);
        for (int k = 0; k < 8; k++) begin
            cfg(k, $urandom_range(7, 0), $urandom_range(64, 0), $urandom_range(96, 0));
            repeat (80) step(1'($urandom_range(3, 0) != 0), 1'($urandom_range(1, 0)));
        end
        complete_run();
    end
endmodule // fth_top_test
